// ==== timer_two_pkg.sv ====
// Constants shared by the asynchronous-capable 8-bit timer register block
// How it works
// - Force strobe acts only in non-PWM modes
// - Forced compare sets no flag, clears nothing
// - Force strobe bits always read zero
// - Clock select: stop, undivided, 8..1024 prescaled
// - Counter write blocks next tick's compare match
// - Compare registers matched continuously, set flags
// - Interrupt needs enable, flag and global enable
// - Flags set by events, cleared by ack/W1C
// - Phase-correct overflow flag at bottom direction change
// - External clock buffer replaces crystal when enabled with async select
// - Async select picks I/O or oscillator clock
// - Async writes set busy until transferred
// - Counter reads live; control and compare registers read temporary copy
// - Prescaler reset bit held until reset done
// - Sync-hold bit keeps prescaler reset set
// - Reserved bits read as zero
// - Mode top bit joins low bits for mode
package timer_two_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SYNC_PRESC = 6'h23;
  localparam logic [5:0] IDX_CTL_A      = 6'h30;
  localparam logic [5:0] IDX_CTL_B      = 6'h31;
  localparam logic [5:0] IDX_COUNT      = 6'h32;
  localparam logic [5:0] IDX_CMP_A      = 6'h33;
  localparam logic [5:0] IDX_CMP_B      = 6'h34;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h35;
  localparam logic [5:0] IDX_IRQ_FLAGS  = 6'h36;
  localparam logic [5:0] IDX_ASYNC_STAT = 6'h37;
  // Field positions
  localparam int FORCE_A_BIT   = 7;
  localparam int FORCE_B_BIT   = 6;
  localparam int TOP_MODE_BIT  = 3;
  localparam int ASYNC_PRE_BIT = 1;
  localparam int SYNC_PRE_BIT  = 0;
  localparam int SYNC_HOLD_BIT = 7;
  localparam int EXT_CLK_BIT   = 6;
  localparam int ASYNC_SEL_BIT = 5;
  // Busy bit positions in the asynchronous status register
  localparam int BUSY_COUNT = 4;
  localparam int BUSY_CMP_A = 3;
  localparam int BUSY_CMP_B = 2;
  localparam int BUSY_CTL_A = 1;
  localparam int BUSY_CTL_B = 0;
  // Read masks that force reserved bits to zero
  localparam logic [7:0] CTL_A_RD_MASK = 8'hF3;
  localparam logic [7:0] CTL_B_RD_MASK = 8'h0F;
  // Values after reset
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [9:0] PRE_RESET  = 10'h000;
  // Counter limits
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  // Prescaler tap masks (divisor minus one)
  localparam logic [9:0] TAP_DIV8    = 10'h007;
  localparam logic [9:0] TAP_DIV32   = 10'h01F;
  localparam logic [9:0] TAP_DIV64   = 10'h03F;
  localparam logic [9:0] TAP_DIV128  = 10'h07F;
  localparam logic [9:0] TAP_DIV256  = 10'h0FF;
  localparam logic [9:0] TAP_DIV1024 = 10'h3FF;
  // Clock select codes
  localparam logic [2:0] CS_STOP   = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  // Compare output mode codes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;
endpackage

// ==== sync_edge.sv ====
// Two-flop synchroniser with rising-edge detect for the oscillator pin
`timescale 1ns/100ps
module sync_edge (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic din,
  output logic      level,
  output logic      rise
);
  logic metaStage;
  logic prevLevel;

  // First stage feeds only the second stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      metaStage <= 1'b0;
      level     <= 1'b0;
      prevLevel <= 1'b0;
    end else begin
      metaStage <= din;
      level     <= metaStage;
      prevLevel <= level;
    end
  end

  assign rise = level & ~prevLevel;
endmodule

// ==== timer_two_regs.sv ====
// Asynchronous-capable 8-bit timer with APB register access
`timescale 1ns/100ps
module timer_two_regs (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timerOscIn,
  input  wire logic        globalIrqEn,
  input  wire logic        ackCmpA,
  input  wire logic        ackCmpB,
  input  wire logic        ackOvf,
  output logic             irqCmpA,
  output logic             irqCmpB,
  output logic             irqOvf,
  output logic             waveOutA,
  output logic             waveOutB,
  output logic             waveOutEnA,
  output logic             waveOutEnB,
  output logic             crystalOscEn,
  output logic             extClkBufEn,
  output logic             syncPrescalerRst
);
  import timer_two_pkg::*;

  // Register state
  logic [7:0] ctlATemp;
  logic [7:0] ctlBTemp;
  logic [7:0] countTemp;
  logic [7:0] cmpATemp;
  logic [7:0] cmpBTemp;
  logic [7:0] ctlA;
  logic [7:0] ctlB;
  logic [7:0] count;
  logic [7:0] cmpA;
  logic [7:0] cmpB;
  logic [2:0] irqMask;
  logic [2:0] flags;
  logic       extClkInEn;
  logic       asyncClkSel;
  logic [4:0] busy;
  logic       syncHold;
  logic       asyncPreRst;
  logic       syncPreRst;
  logic [9:0] pre;
  logic       dirDown;
  logic       blockMatch;
  logic       waveA;
  logic       waveB;

  // Oscillator pin passes two flops before use
  logic oscLevel;
  logic oscRise;

  sync_edge sync_edge_inst (
    .clock (clock),
    .rst   (rst),
    .din   (timerOscIn),
    .level (oscLevel),
    .rise  (oscRise)
  );

  // Bus decode
  wire       setupPhase = psel & ~penable;
  wire       accessPhase = psel & penable;
  wire [5:0] regIdx = paddr[7:2];
  wire       wr = accessPhase & pwrite;
  wire       hitGtc = regIdx == IDX_SYNC_PRESC;
  wire       hitCtlA = regIdx == IDX_CTL_A;
  wire       hitCtlB = regIdx == IDX_CTL_B;
  wire       hitCount = regIdx == IDX_COUNT;
  wire       hitCmpA = regIdx == IDX_CMP_A;
  wire       hitCmpB = regIdx == IDX_CMP_B;
  wire       hitMask = regIdx == IDX_IRQ_MASK;
  wire       hitFlags = regIdx == IDX_IRQ_FLAGS;
  wire       hitStat = regIdx == IDX_ASYNC_STAT;
  wire       mapped = hitGtc | hitCtlA | hitCtlB | hitCount | hitCmpA | hitCmpB | hitMask | hitFlags | hitStat;
  wire       wrGtc = wr & hitGtc;
  wire       wrMask = wr & hitMask;
  wire       wrFlags = wr & hitFlags;
  wire       wrStat = wr & hitStat;
  wire [7:0] wByte = pwdata[7:0];

  // Writes to the five buffered registers, in busy-bit order
  wire [4:0] wrVec = {wr & hitCount, wr & hitCmpA, wr & hitCmpB, wr & hitCtlA, wr & hitCtlB};

  // Tick from the selected source: every I/O clock or each rising oscillator edge
  wire srcTick = asyncClkSel ? oscRise : 1'b1;

  // Immediate load in sync mode, transfer of busy copies on the next source tick otherwise
  wire [4:0] loadVec = asyncClkSel ? (busy & {5{srcTick}}) : wrVec;
  wire [7:0] ctlBSrc = asyncClkSel ? ctlBTemp : wByte;
  wire [7:0] ctlASrc = asyncClkSel ? ctlATemp : wByte;
  wire [7:0] countSrc = asyncClkSel ? countTemp : wByte;
  wire [7:0] cmpASrc = asyncClkSel ? cmpATemp : wByte;
  wire [7:0] cmpBSrc = asyncClkSel ? cmpBTemp : wByte;
  wire       loadCount = loadVec[BUSY_COUNT];
  wire       loadCtlB = loadVec[BUSY_CTL_B];

  // Mode decode from the top bit and the two low bits
  wire [2:0] waveMode = {ctlB[TOP_MODE_BIT], ctlA[1:0]};
  wire       pwmMode = waveMode[0];
  wire       phaseCorrect = waveMode[1:0] == 2'b01;
  wire       fastPwm = waveMode[1:0] == 2'b11;
  wire [7:0] topValue = waveMode[2] ? cmpA : COUNT_MAX;
  wire [1:0] comA = ctlA[7:6];
  wire [1:0] comB = ctlA[5:4];
  wire [2:0] clkSelect = ctlB[2:0];

  // Prescaler tap selection
  wire [9:0] tapMask = (clkSelect == 3'h2) ? TAP_DIV8 :
                       (clkSelect == 3'h3) ? TAP_DIV32 :
                       (clkSelect == 3'h4) ? TAP_DIV64 :
                       (clkSelect == 3'h5) ? TAP_DIV128 :
                       (clkSelect == 3'h6) ? TAP_DIV256 : TAP_DIV1024;
  wire tapHit = srcTick & ~asyncPreRst & ((pre & tapMask) == tapMask);
  wire timerTick = (clkSelect == CS_STOP) ? 1'b0 :
                   (clkSelect == CS_DIRECT) ? srcTick : tapHit;

  // Counting events
  wire atTop = count == topValue;
  wire atBottom = count == COUNT_BOTTOM;
  wire turnBottom = timerTick & phaseCorrect & dirDown & atBottom;
  wire wrapEvent = timerTick & ~phaseCorrect & atTop;
  wire ovfEvent = phaseCorrect ? turnBottom
                               : timerTick & (fastPwm ? atTop : count == COUNT_MAX);
  wire matchA = timerTick & ~blockMatch & (count == cmpA);
  wire matchB = timerTick & ~blockMatch & (count == cmpB);

  // Forced compares only outside PWM modes, with no flag and no clear
  wire forceA = loadCtlB & ctlBSrc[FORCE_A_BIT] & ~pwmMode;
  wire forceB = loadCtlB & ctlBSrc[FORCE_B_BIT] & ~pwmMode;

  // Next counter value and direction
  logic [7:0] next_count;
  logic       next_dirDown;
  always_comb begin
    next_count = count;
    next_dirDown = dirDown;
    if (loadCount) begin
      next_count = countSrc;
    end else if (timerTick) begin
      if (phaseCorrect) begin
        if (!dirDown && atTop) begin
          next_dirDown = 1'b1;
          next_count = count - 8'h01;
        end else if (dirDown && atBottom) begin
          next_dirDown = 1'b0;
          next_count = count + 8'h01;
        end else begin
          next_count = dirDown ? count - 8'h01 : count + 8'h01;
        end
      end else begin
        next_count = atTop ? COUNT_BOTTOM : count + 8'h01;
      end
    end
  end

  // Output pin action for one channel
  function automatic logic waveNext(input logic cur, input logic [1:0] com, input logic match,
                                    input logic forced, input logic wrap, input logic down,
                                    input logic toggleOk, input logic pwm, input logic pc);
    logic hit;
    hit = match | forced;
    waveNext = cur;
    if (!pwm) begin
      if (hit) begin
        unique case (com)
          COM_OFF:    waveNext = cur;
          COM_TOGGLE: waveNext = ~cur;
          COM_CLEAR:  waveNext = 1'b0;
          COM_SET:    waveNext = 1'b1;
        endcase
      end
    end else if (com == COM_TOGGLE) begin
      if (match && toggleOk) begin
        waveNext = ~cur;
      end
    end else if (com[1]) begin
      if (pc && match) begin
        waveNext = com[0] ^ down;
      end else if (!pc && match) begin
        waveNext = com[0];
      end else if (!pc && wrap) begin
        waveNext = ~com[0];
      end
    end
  endfunction

  wire next_waveA = waveNext(waveA, comA, matchA, forceA, wrapEvent, dirDown, waveMode[2], pwmMode, phaseCorrect);
  wire next_waveB = waveNext(waveB, comB, matchB, forceB, wrapEvent, dirDown, 1'b0, pwmMode, phaseCorrect);

  // Flags: events win over acknowledge and write-one-to-clear
  wire [2:0] flagSet = {matchB, matchA, ovfEvent};
  wire [2:0] flagClr = ({3{wrFlags}} & wByte[2:0]) | {ackCmpB, ackCmpA, ackOvf};
  wire [2:0] next_flags = (flags & ~flagClr) | flagSet;

  // Busy bits: a new write wins over the transfer that clears them
  wire [4:0] next_busy = asyncClkSel ? (wrVec | (busy & ~{5{srcTick}})) : 5'h00;

  // Prescaler reset bit: held by sync-hold, held in async until a source tick
  logic next_asyncPreRst;
  always_comb begin
    if (wrGtc && wByte[ASYNC_PRE_BIT]) begin
      next_asyncPreRst = 1'b1;
    end else if (syncHold) begin
      next_asyncPreRst = asyncPreRst;
    end else if (asyncPreRst && (!asyncClkSel || srcTick)) begin
      next_asyncPreRst = 1'b0;
    end else begin
      next_asyncPreRst = asyncPreRst;
    end
  end

  wire next_syncPreRst = (wrGtc & wByte[SYNC_PRE_BIT]) | (syncPreRst & syncHold);

  // Read data with reserved bits at zero
  wire [7:0] rdByte = hitGtc ? {syncHold, 5'h00, asyncPreRst, syncPreRst} :
                      hitCtlA ? (ctlATemp & CTL_A_RD_MASK) :
                      hitCtlB ? (ctlBTemp & CTL_B_RD_MASK) :
                      hitCount ? count :
                      hitCmpA ? cmpATemp :
                      hitCmpB ? cmpBTemp :
                      hitMask ? {5'h00, irqMask} :
                      hitFlags ? {5'h00, flags} :
                      hitStat ? {1'b0, extClkInEn, asyncClkSel, busy} : BYTE_RESET;

  // Bus response: data captured in setup, zero wait states
  assign pready = 1'b1;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata  <= {24'h00_0000, rdByte};
      pslverr <= ~mapped;
    end
  end

  // Temporary storage registers always take the bus value
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctlATemp  <= BYTE_RESET;
      ctlBTemp  <= BYTE_RESET;
      countTemp <= BYTE_RESET;
      cmpATemp  <= BYTE_RESET;
      cmpBTemp  <= BYTE_RESET;
    end else begin
      if (wrVec[BUSY_CTL_A]) ctlATemp <= wByte;
      if (wrVec[BUSY_CTL_B]) ctlBTemp <= wByte;
      if (wrVec[BUSY_COUNT]) countTemp <= wByte;
      if (wrVec[BUSY_CMP_A]) cmpATemp <= wByte;
      if (wrVec[BUSY_CMP_B]) cmpBTemp <= wByte;
    end
  end

  // Working copies used by the counter; force bits never stored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctlA <= BYTE_RESET;
      ctlB <= BYTE_RESET;
      cmpA <= BYTE_RESET;
      cmpB <= BYTE_RESET;
    end else begin
      if (loadVec[BUSY_CTL_A]) ctlA <= ctlASrc;
      if (loadCtlB) ctlB <= ctlBSrc & CTL_B_RD_MASK;
      if (loadVec[BUSY_CMP_A]) cmpA <= cmpASrc;
      if (loadVec[BUSY_CMP_B]) cmpB <= cmpBSrc;
    end
  end

  // Counter, direction and compare blocking after a counter write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count      <= BYTE_RESET;
      dirDown    <= 1'b0;
      blockMatch <= 1'b0;
    end else begin
      count   <= next_count;
      dirDown <= next_dirDown;
      if (loadCount) begin
        blockMatch <= 1'b1;
      end else if (timerTick) begin
        blockMatch <= 1'b0;
      end
    end
  end

  // Prescaler runs on source ticks and is held while its reset bit is set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre <= PRE_RESET;
    end else if (asyncPreRst) begin
      pre <= PRE_RESET;
    end else if (srcTick) begin
      pre <= pre + 10'h001;
    end
  end

  // Mask, flags, status and general control
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irqMask     <= 3'h0;
      flags       <= 3'h0;
      extClkInEn  <= 1'b0;
      asyncClkSel <= 1'b0;
      busy        <= 5'h00;
      syncHold    <= 1'b0;
      asyncPreRst <= 1'b0;
      syncPreRst  <= 1'b0;
    end else begin
      if (wrMask) irqMask <= wByte[2:0];
      flags <= next_flags;
      if (wrStat) begin
        extClkInEn  <= wByte[EXT_CLK_BIT];
        asyncClkSel <= wByte[ASYNC_SEL_BIT];
      end
      busy <= next_busy;
      if (wrGtc) syncHold <= wByte[SYNC_HOLD_BIT];
      asyncPreRst <= next_asyncPreRst;
      syncPreRst  <= next_syncPreRst;
    end
  end

  // Waveform outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waveA <= 1'b0;
      waveB <= 1'b0;
    end else begin
      waveA <= next_waveA;
      waveB <= next_waveB;
    end
  end

  assign waveOutA = waveA;
  assign waveOutB = waveB;
  assign waveOutEnA = comA != COM_OFF;
  assign waveOutEnB = comB != COM_OFF;

  // Interrupt requests
  assign irqCmpB = irqMask[2] & flags[2] & globalIrqEn;
  assign irqCmpA = irqMask[1] & flags[1] & globalIrqEn;
  assign irqOvf = irqMask[0] & flags[0] & globalIrqEn;

  // Oscillator pad control: crystal only while external clock is off
  assign crystalOscEn = ~extClkInEn;
  assign extClkBufEn = extClkInEn & asyncClkSel;
  assign syncPrescalerRst = syncPreRst;
endmodule

// ==== timer_two_regs_sva.sv ====
// Checker for the timer register block, seen from its top-level ports
`timescale 1ns/100ps
module timer_two_regs_sva
  import timer_two_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        globalIrqEn,
  input wire logic        irqCmpA,
  input wire logic        irqCmpB,
  input wire logic        irqOvf,
  input wire logic        crystalOscEn,
  input wire logic        extClkBufEn
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Decode of a read access phase
  logic [5:0] idx;
  logic       rdAcc;
  assign idx   = paddr[7:2];
  assign rdAcc = psel && penable && !pwrite;
  // Register read fields
  a_force_read_zero:
    assert property (rdAcc && idx == IDX_CTL_B |-> prdata[7:6] == 2'h0) else $error("force bits read nonzero");
  a_ctlb_reserved_zero:
    assert property (rdAcc && idx == IDX_CTL_B |-> prdata[5:4] == 2'h0) else $error("control B reserved nonzero");
  a_status_reserved_zero:
    assert property (rdAcc && idx == IDX_ASYNC_STAT |-> !prdata[7]) else $error("status bit 7 nonzero");
  a_general_reserved_zero:
    assert property (rdAcc && idx == IDX_SYNC_PRESC |-> prdata[6:2] == 5'h00) else $error("general reserved nonzero");
  a_read_data_stands:
    assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved without setup");
  // Interrupt gating
  a_irq_cmp_a_gate:
    assert property (irqCmpA |-> globalIrqEn) else $error("compare A irq without global enable");
  a_irq_cmp_b_gate:
    assert property (irqCmpB |-> globalIrqEn) else $error("compare B irq without global enable");
  a_irq_ovf_gate:
    assert property (irqOvf |-> globalIrqEn) else $error("overflow irq without global enable");
  // Oscillator selection
  a_crystal_off_ext:
    assert property (extClkBufEn |-> !crystalOscEn) else $error("crystal runs with external clock");
endmodule
bind timer_two_regs timer_two_regs_sva timer_two_regs_sva_inst (.clock, .rst, .paddr, .psel, .penable, .pwrite,
  .prdata, .globalIrqEn, .irqCmpA, .irqCmpB, .irqOvf, .crystalOscEn, .extClkBufEn);

// ==== test_timer_two_regs.sv ====
// Self-checking bench for the timer register block over APB
`timescale 1ns/100ps
module test_timer_two_regs;
  import timer_two_pkg::*;
  localparam logic [7:0] GEN = {IDX_SYNC_PRESC, 2'h0};
  localparam logic [7:0] CTA = {IDX_CTL_A, 2'h0};
  localparam logic [7:0] CTB = {IDX_CTL_B, 2'h0};
  localparam logic [7:0] CNT = {IDX_COUNT, 2'h0};
  localparam logic [7:0] CMA = {IDX_CMP_A, 2'h0};
  localparam logic [7:0] CMB = {IDX_CMP_B, 2'h0};
  localparam logic [7:0] MSK = {IDX_IRQ_MASK, 2'h0};
  localparam logic [7:0] FLG = {IDX_IRQ_FLAGS, 2'h0};
  localparam logic [7:0] STA = {IDX_ASYNC_STAT, 2'h0};
  localparam logic [71:0] ALL = {GEN, CTA, CTB, CNT, CMA, CMB, MSK, FLG, STA};
  logic        clock, rst, psel, penable, pwrite, timerOscIn, globalIrqEn, ackCmpA, ackCmpB, ackOvf;
  logic [7:0]  paddr, rdata;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, rerr, irqCmpA, irqCmpB, irqOvf, waveOutA, waveOutB;
  logic        waveOutEnA, waveOutEnB, crystalOscEn, extClkBufEn, syncPrescalerRst;
  int          nMismatch, checkCount;
  int          divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  timer_two_regs timer_two_regs_inst (.clock, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .timerOscIn, .globalIrqEn, .ackCmpA, .ackCmpB, .ackOvf, .irqCmpA, .irqCmpB, .irqOvf, .waveOutA,
    .waveOutB, .waveOutEnA, .waveOutEnB, .crystalOscEn, .extClkBufEn, .syncPrescalerRst);
  // Clock source
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // One APB transfer; waits for pready, takes read data at that edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdata = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rdata, exp);
  endtask
  task automatic inRange(input logic [7:0] got, input int lo, input int hi);
    checkCount++;
    if ($isunknown(got) || got < lo || got > hi) begin
      nMismatch++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  // Waits n edges, then samples at the settled falling edge
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic testDone;
    $display("mismatches %0d, checks %0d", nMismatch, checkCount);
    if (nMismatch == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge clock);
    nMismatch++;
    testDone;
  end
  // Test sequence
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h00000000;
    timerOscIn = 1'b0; globalIrqEn = 1'b0; ackCmpA = 1'b0; ackCmpB = 1'b0; ackOvf = 1'b0;
    nMismatch = 0; checkCount = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rdchk(ALL[i*8 +: 8], 8'h00);
    xfer(1'b0, 8'h00, 8'h00);
    chk({7'h00, rerr}, 8'h01);
    chk(rdata, 8'h00);
    $display("reset and map test done");
    wr(CTA, 8'hFF); rdchk(CTA, CTL_A_RD_MASK);
    wr(CTB, 8'hC8); rdchk(CTB, 8'h08);
    wr(CTB, 8'h00); wr(GEN, 8'h7C); rdchk(GEN, 8'h00);
    wr(STA, 8'h80); rdchk(STA, 8'h00);
    $display("reserved bits test done");
    wr(CTA, 8'h50); wr(CTB, 8'hC0); settle(2);
    chk({6'h00, waveOutA, waveOutB}, 8'h03);
    chk({6'h00, waveOutEnA, waveOutEnB}, 8'h03);
    rdchk(FLG, 8'h00);
    wr(CTA, 8'h51); wr(CTB, 8'hC0); settle(2);
    chk({6'h00, waveOutA, waveOutB}, 8'h03);
    $display("force compare test done");
    wr(CTA, 8'h00); wr(CMA, 8'h05); wr(CMB, 8'h0A); wr(CNT, 8'h00);
    wr(CTB, 8'h01); repeat (16) @(posedge clock); wr(CTB, 8'h00);
    rdchk(FLG, 8'h06);
    @(posedge clock) globalIrqEn <= 1'b1;
    wr(MSK, 8'h02); settle(1); chk({6'h00, irqCmpA, irqCmpB}, 8'h02);
    wr(MSK, 8'h07); settle(1); chk({6'h00, irqCmpA, irqCmpB}, 8'h03);
    @(posedge clock) globalIrqEn <= 1'b0;
    settle(1); chk({6'h00, irqCmpA, irqCmpB}, 8'h00);
    @(posedge clock) globalIrqEn <= 1'b1;
    @(posedge clock) ackCmpA <= 1'b1;
    @(posedge clock) ackCmpA <= 1'b0;
    rdchk(FLG, 8'h04);
    wr(FLG, 8'h00); rdchk(FLG, 8'h04);
    wr(FLG, 8'h04); rdchk(FLG, 8'h00);
    $display("compare and interrupt test done");
    wr(CMA, 8'h80); wr(CMB, 8'h82); wr(CTB, 8'h01);
    wr(CNT, 8'h80); repeat (2) @(posedge clock); wr(CTB, 8'h00);
    rdchk(FLG, 8'h04);
    @(posedge clock) ackCmpB <= 1'b1;
    @(posedge clock) ackCmpB <= 1'b0;
    rdchk(FLG, 8'h00);
    wr(CTB, 8'h01); wr(CNT, 8'hFE); repeat (4) @(posedge clock); wr(CTB, 8'h00);
    rdchk(FLG, 8'h01);
    settle(1); chk({7'h00, irqOvf}, 8'h01);
    @(posedge clock) ackOvf <= 1'b1;
    @(posedge clock) ackOvf <= 1'b0;
    settle(1); chk({7'h00, irqOvf}, 8'h00);
    $display("counter write and overflow test done");
    wr(CNT, 8'h00); repeat (40) @(posedge clock); rdchk(CNT, 8'h00);
    for (int c = 1; c < 8; c++) begin
      wr(CNT, 8'h00); wr(GEN, 8'h02); wr(CTB, c[7:0]);
      // The stop write's three edges still tick, so wait three fewer
      repeat (4 * divs[c] - 3) @(posedge clock);
      wr(CTB, 8'h00);
      xfer(1'b0, CNT, 8'h00);
      inRange(rdata, 3, 6);
    end
    $display("clock select test done");
    wr(STA, 8'h40); settle(1); chk({6'h00, crystalOscEn, extClkBufEn}, 8'h00);
    wr(STA, 8'h60); settle(1); chk({6'h00, crystalOscEn, extClkBufEn}, 8'h01);
    wr(CMA, 8'h33); wr(CNT, 8'h10); wr(GEN, 8'h02);
    rdchk(STA, 8'h78);
    rdchk(CMA, 8'h33);
    rdchk(GEN, 8'h02);
    @(posedge clock) timerOscIn <= 1'b1;
    repeat (5) @(posedge clock);
    timerOscIn <= 1'b0;
    repeat (5) @(posedge clock);
    rdchk(STA, 8'h60);
    rdchk(CNT, 8'h10);
    rdchk(GEN, 8'h00);
    wr(STA, 8'h00); settle(1); chk({7'h00, crystalOscEn}, 8'h01);
    $display("asynchronous mode test done");
    wr(GEN, 8'h02); rdchk(GEN, 8'h00);
    wr(GEN, 8'h01); settle(3); chk({7'h00, syncPrescalerRst}, 8'h00);
    wr(GEN, 8'h83); settle(3); chk({7'h00, syncPrescalerRst}, 8'h01);
    rdchk(GEN, 8'h83);
    wr(GEN, 8'h00); settle(3); chk({7'h00, syncPrescalerRst}, 8'h00);
    $display("prescaler reset test done");
    // Phase correct with compare A as top: turn at top, overflow only at bottom
    wr(CMA, 8'h04); wr(CTA, 8'h01); wr(CNT, 8'h00); wr(FLG, 8'h07);
    wr(CTB, 8'h09); repeat (3) @(posedge clock); wr(CTB, 8'h00);
    rdchk(CNT, 8'h02);
    rdchk(FLG, 8'h02);
    wr(CTB, 8'h09); repeat (3) @(posedge clock); wr(CTB, 8'h00);
    rdchk(FLG, 8'h03);
    $display("phase correct test done");
    testDone;
  end
endmodule
